// [lmrr_pkg.sv]
// constants and types for the led matrix row refresh engine
package lmrr_pkg;
    localparam int unsigned LMRR_CLK_HZ = 250_000_000;
    localparam int unsigned LMRR_ROWS = 8;
    localparam int unsigned LMRR_COLS = 20;
    localparam int unsigned LMRR_DOTS = 160;
    localparam int unsigned LMRR_FRAME_CYCLES = 512;
    localparam int unsigned LMRR_SLOT_CYCLES = 64;
    localparam int unsigned LMRR_CNT_W = 9;
    localparam int unsigned LMRR_PHASE_W = 6;
    localparam int unsigned LMRR_ROW_W = 3;
    localparam logic [5:0] LMRR_BLANK_CYCLES = 6'h04;
    localparam logic [5:0] LMRR_MAX_ON = 6'h3C;
    localparam logic [5:0] LMRR_SLOT_LAST = 6'h3F;
    localparam logic [8:0] LMRR_FRAME_LAST = 9'h1FF;
    localparam logic [2:0] LMRR_UNLIT_ROW = 3'h0;
    localparam logic [2:0] LMRR_PRESCALE_LAST = 3'h7;
    localparam int unsigned LMRR_PRESCALE_DIV = 8;
    localparam int unsigned LMRR_INT_OSC_HZ = 256_000;

    // on-cycles per row slot for each pwm code; code 13 gives 60% of 60
    localparam logic [5:0] LMRR_PWM_ON [16] = '{
        6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h08,
        6'h0A, 6'h0D, 6'h10, 6'h14, 6'h1A, 6'h24, 6'h2E, 6'h3C
    };
    // relative peak current in percent of full scale per peak code
    localparam logic [6:0] LMRR_PEAK_PCT [4] = '{7'h49, 7'h32, 7'h64, 7'h5D};

    typedef struct packed {
        logic sleep_control_bit;
        logic peak_current_bit_high;
        logic peak_current_bit_low;
        logic pwm_bit_3;
        logic pwm_bit_2;
        logic pwm_bit_1;
        logic pwm_bit_0;
    } lmrr_ctrl0_s;

    typedef struct packed {
        logic osc_select_ext;
        logic ext_prescale;
    } lmrr_osc_cfg_s;

    typedef enum logic [1:0] {
        LMRR_ST_SLEEP = 2'b01,
        LMRR_ST_RUN = 2'b10
    } lmrr_state_e;
endpackage

// [lmrr_row_refresh.sv]
// row-scan refresh engine driving row sinks and column current sources
`timescale 1ns/1ns
`default_nettype none

// Operation
// [R1] one refresh lasts exactly 512 display cycles
// [R2] rows enabled singly, seven of eight per refresh (row zero never enabled)
// [R3] each row slot lasts 64 display cycles
// [R4] four blank cycles start every row slot
// [R5] on-time never exceeds 60 of 64 cycles
// [R6] 160 dot bits form 20 columns, 8 rows
// [R7] each column selects its bit by row
// [R8] at most 20 leds lit, one row
// [R9] display timing from internal or external oscillator
// [R10] duty equals one eighth times on/64
// [R11] pwm and peak current from brightness word
// [R12] both peak bits low gives 73 percent
// [R13] pwm code 1101 gives 60 percent on-time
// [R14] host supplies external oscillator at least 51.2kHz
// [R15] prescaler divides only external oscillator by eight
// [R16] sleep stops oscillator, blanks drivers, keeps data
// [R17] row zero scanned but never lit
// [R18] nine-bit counter: row high, phase low
// [R19] brightness changes apply at slot boundary
module lmrr_row_refresh #(
    parameter int unsigned INT_OSC_HZ = lmrr_pkg::LMRR_INT_OSC_HZ,
    parameter int unsigned INT_OSC_DIV = lmrr_pkg::LMRR_CLK_HZ / INT_OSC_HZ
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [lmrr_pkg::LMRR_DOTS-1:0] dot_latch_in,
    input wire lmrr_pkg::lmrr_ctrl0_s ctrl0_in,
    input wire lmrr_pkg::lmrr_osc_cfg_s osc_cfg_in,
    input wire logic ext_osc_in,
    output logic [lmrr_pkg::LMRR_ROWS-1:0] row_sink_out,
    output logic [lmrr_pkg::LMRR_COLS-1:0] col_drive_out,
    output logic [6:0] col_current_pct_out,
    output logic [lmrr_pkg::LMRR_ROW_W-1:0] row_index_out,
    output logic frame_done_out,
    output logic sleeping_out
);
    import lmrr_pkg::*;

    localparam logic [15:0] INT_DIV_LAST = 16'(INT_OSC_DIV - 1);

    // the divider counter is 16 bits wide and needs at least two states
    if (INT_OSC_DIV < 2 || INT_OSC_DIV > 65536) begin : g_div_check
        $error("internal oscillator divider out of range");
    end

    lmrr_state_e state_ff;
    logic [15:0] int_div_ff;
    logic int_tick;
    logic ext_meta_ff;
    logic ext_sync_ff;
    logic ext_prev_ff;
    logic ext_edge;
    logic [2:0] pre_cnt_ff;
    logic ext_tick;
    logic disp_tick;
    logic [LMRR_CNT_W-1:0] refresh_cnt_ff;
    logic [LMRR_CNT_W-1:0] nxt_refresh_cnt;
    logic [LMRR_ROW_W-1:0] row;
    logic [LMRR_PHASE_W-1:0] phase;
    logic slot_end;
    logic [5:0] on_cycles_ff;
    logic [1:0] peak_code_ff;
    logic on_window;
    logic [LMRR_COLS-1:0] col_sel;
    logic drive_en;

    // sleep is entered while the control bit is low; data ports are untouched
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_ff <= LMRR_ST_SLEEP;
        end else begin
            unique case (state_ff)
                LMRR_ST_SLEEP: begin
                    if (ctrl0_in.sleep_control_bit) begin
                        state_ff <= LMRR_ST_RUN;
                    end
                end
                LMRR_ST_RUN: begin
                    if (!ctrl0_in.sleep_control_bit) begin
                        state_ff <= LMRR_ST_SLEEP;
                    end
                end
                default: begin
                    state_ff <= LMRR_ST_SLEEP;
                end
            endcase
        end
    end

    // internal oscillator: held stopped in sleep to save the toggling
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            int_div_ff <= 16'h0000;
        end else if (state_ff == LMRR_ST_SLEEP) begin
            int_div_ff <= 16'h0000; // see [R16]
        end else if (int_div_ff == INT_DIV_LAST) begin
            int_div_ff <= 16'h0000;
        end else begin
            int_div_ff <= int_div_ff + 16'h0001;
        end
    end

    assign int_tick = (state_ff == LMRR_ST_RUN) && (int_div_ff == INT_DIV_LAST);

    // external oscillator pin crosses into clk_sys through two flops
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ext_meta_ff <= 1'b0;
            ext_sync_ff <= 1'b0;
            ext_prev_ff <= 1'b0;
        end else begin
            ext_meta_ff <= ext_osc_in;
            ext_sync_ff <= ext_meta_ff;
            ext_prev_ff <= ext_sync_ff;
        end
    end

    assign ext_edge = ext_sync_ff && !ext_prev_ff;

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pre_cnt_ff <= 3'h0;
        end else if (!osc_cfg_in.ext_prescale) begin
            pre_cnt_ff <= 3'h0;
        end else if (ext_edge) begin
            pre_cnt_ff <= pre_cnt_ff + 3'h1; // see [R15]
        end
    end

    // prescaler applies only to the external source
    assign ext_tick = ext_edge && (!osc_cfg_in.ext_prescale || pre_cnt_ff == LMRR_PRESCALE_LAST); // see [R15]
    assign disp_tick = osc_cfg_in.osc_select_ext ? ext_tick : int_tick; // see [R9]

    // refresh counter: row in the upper bits, slot phase in the lower bits
    assign row = refresh_cnt_ff[LMRR_CNT_W-1:LMRR_PHASE_W]; // see [R18]
    assign phase = refresh_cnt_ff[LMRR_PHASE_W-1:0]; // see [R18]
    assign slot_end = disp_tick && (phase == LMRR_SLOT_LAST); // see [R3]
    assign nxt_refresh_cnt = refresh_cnt_ff + 9'h001; // wraps to row 0, see [R1]

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            refresh_cnt_ff <= 9'h000;
        end else if (disp_tick) begin
            refresh_cnt_ff <= nxt_refresh_cnt; // see [R1] [R2] [R3]
        end
    end

    // brightness sampled only at slot boundaries so a running slot keeps its length
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            on_cycles_ff <= 6'h00;
            peak_code_ff <= 2'h0;
        end else if (slot_end) begin
            on_cycles_ff <= LMRR_PWM_ON[{ctrl0_in.pwm_bit_3, ctrl0_in.pwm_bit_2,
                                         ctrl0_in.pwm_bit_1, ctrl0_in.pwm_bit_0}]; // see [R19] [R11] [R13]
            peak_code_ff <= {ctrl0_in.peak_current_bit_high, ctrl0_in.peak_current_bit_low}; // see [R19] [R11]
        end
    end

    // on window follows the blank; duty is on_cycles/64 of each of the slots for rows 1 to 7, row 0 stays dark
    assign on_window = (phase >= LMRR_BLANK_CYCLES)
        && ((phase - LMRR_BLANK_CYCLES) < on_cycles_ff)
        && ((phase - LMRR_BLANK_CYCLES) < LMRR_MAX_ON); // see [R4] [R5] [R10]
    assign drive_en = on_window && (state_ff == LMRR_ST_RUN) && (row != LMRR_UNLIT_ROW); // see [R16] [R17]

    // one-of-eight selector per column
    for (genvar c = 0; c < LMRR_COLS; c++) begin : g_col
        assign col_sel[c] = dot_latch_in[c * LMRR_ROWS + int'(row)]; // see [R6] [R7]
    end

    // outputs are registered so the pins never glitch on counter carries
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            row_sink_out <= 8'h00;
            col_drive_out <= 20'h00000;
        end else if (drive_en) begin
            row_sink_out <= 8'h01 << row; // see [R2] [R8]
            col_drive_out <= col_sel; // see [R7] [R8]
        end else begin
            row_sink_out <= 8'h00;
            col_drive_out <= 20'h00000; // see [R4] [R16]
        end
    end

    // current level multiplies with the pwm window at the column source
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            col_current_pct_out <= 7'h00;
        end else if (drive_en) begin
            col_current_pct_out <= LMRR_PEAK_PCT[peak_code_ff]; // see [R11] [R12]
        end else begin
            col_current_pct_out <= 7'h00;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            row_index_out <= 3'h0;
            frame_done_out <= 1'b0;
            sleeping_out <= 1'b1;
        end else begin
            row_index_out <= row;
            frame_done_out <= disp_tick && (refresh_cnt_ff == LMRR_FRAME_LAST); // see [R1]
            sleeping_out <= (state_ff == LMRR_ST_SLEEP);
        end
    end

    // checks

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);

    logic [9:0] chk_ticks_ff;

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            chk_ticks_ff <= 10'h000;
        end else if (disp_tick && refresh_cnt_ff == LMRR_FRAME_LAST) begin
            chk_ticks_ff <= 10'h000;
        end else if (disp_tick) begin
            chk_ticks_ff <= chk_ticks_ff + 10'h001;
        end
    end

    // external pin edges since the last divided tick, counted apart from the prescaler itself
    logic [3:0] chk_edges_ff;

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            chk_edges_ff <= 4'h0;
        end else if (!osc_cfg_in.ext_prescale) begin
            chk_edges_ff <= 4'h0;
        end else if (ext_edge && chk_edges_ff == 4'h7) begin
            chk_edges_ff <= 4'h0;
        end else if (ext_edge) begin
            chk_edges_ff <= chk_edges_ff + 4'h1;
        end
    end

    sequence frame_wrap_s;
        disp_tick && (refresh_cnt_ff == LMRR_FRAME_LAST);
    endsequence

    sequence slot_boundary_s;
        disp_tick && (phase == LMRR_SLOT_LAST);
    endsequence

    sequence blank_phase_s;
        phase < LMRR_BLANK_CYCLES;
    endsequence

    frame_length_a: assert property ( // see [R1]
        frame_wrap_s |-> chk_ticks_ff == 10'h1FF ##1 refresh_cnt_ff == 9'h000
    ) else $error("refresh frame did not wrap after 512 display cycles");

    row_single_a: assert property ( // see [R2]
        $onehot0(row_sink_out) && (row_sink_out == 8'h00 || row_sink_out == (8'h01 << row_index_out))
    ) else $error("more than one row sink or wrong row active");

    slot_advance_a: assert property ( // see [R3]
        slot_boundary_s ##1 1'b1 |-> row == $past(row) + 3'h1
    ) else $error("row did not advance at end of 64 cycle slot");

    slot_hold_a: assert property ( // see [R3]
        disp_tick && phase != LMRR_SLOT_LAST |=> row == $past(row)
    ) else $error("row changed inside a slot");

    blank_start_a: assert property ( // see [R4]
        blank_phase_s |=> row_sink_out == 8'h00 && col_drive_out == 20'h00000
    ) else $error("outputs lit during slot blank");

    on_limit_a: assert property ( // see [R5]
        {1'b0, phase} >= 7'(LMRR_BLANK_CYCLES) + 7'(on_cycles_ff) |=> col_drive_out == 20'h00000
    ) else $error("leds lit past programmed on-time");

    col_select_a: assert property ( // see [R7]
        drive_en |=> col_drive_out == $past(col_sel) && row_sink_out[row_index_out]
    ) else $error("column output not from active row latch bit");

    row_zero_dark_a: assert property ( // see [R17]
        row == LMRR_UNLIT_ROW |=> row_sink_out == 8'h00 && col_drive_out == 20'h00000
    ) else $error("row zero was lit");

    sleep_dark_a: assert property ( // see [R16]
        !ctrl0_in.sleep_control_bit ##1 state_ff == LMRR_ST_SLEEP |=> row_sink_out == 8'h00 && !int_tick
    ) else $error("drivers or oscillator active in sleep");

    bright_hold_a: assert property ( // see [R19]
        !slot_end |=> $stable(on_cycles_ff) && $stable(peak_code_ff)
    ) else $error("brightness changed inside a slot");

    prescale_div_a: assert property ( // see [R15]
        osc_cfg_in.osc_select_ext && osc_cfg_in.ext_prescale |-> disp_tick == (ext_edge && chk_edges_ff == 4'h7)
    ) else $error("external display tick not divided by eight");

    peak_default_a: assert property ( // see [R12]
        drive_en && peak_code_ff == 2'h0 |=> col_current_pct_out == 7'h49
    ) else $error("peak current not 73 percent for code zero");

endmodule

`default_nettype wire

// [lmrr_led_array_model.sv]
// load model of the led row sinks and column sources, counting lit time per row
`timescale 1ns/1ns
`default_nettype none
module lmrr_led_array_model (
    input wire logic clk_sys_in,
    input wire logic clear_in,
    input wire logic [lmrr_pkg::LMRR_ROWS-1:0] row_sink_in,
    input wire logic [lmrr_pkg::LMRR_COLS-1:0] col_drive_in,
    output logic [15:0] row_on_cnt_out [8],
    output logic over_lit_out
);
    import lmrr_pkg::*;
    // only sink time is counted: a column source without a sunk row lights nothing
    always_ff @(posedge clk_sys_in) begin
        for (int r = 0; r < 8; r++) begin
            if (clear_in) begin
                row_on_cnt_out[r] <= 16'h0000;
            end else if (row_sink_in[r]) begin
                row_on_cnt_out[r] <= row_on_cnt_out[r] + 16'h0001;
            end
        end
    end
    // sticky: two rows at once, or more dots lit than one row can hold
    always_ff @(posedge clk_sys_in) begin
        if (clear_in) begin
            over_lit_out <= 1'b0;
        end else if ($countones(row_sink_in) > 1 || $countones(row_sink_in) * $countones(col_drive_in) > LMRR_COLS) begin
            over_lit_out <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// [tb_top.sv]
// self-checking testbench for the led matrix row refresh engine
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import lmrr_pkg::*;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [159:0] dots = 160'h0123456789ABCDEF_FEDCBA98_76543210_0F1E2D3C;
    lmrr_ctrl0_s ctrl0 = lmrr_ctrl0_s'(7'h0F);
    lmrr_osc_cfg_s osc_cfg = lmrr_osc_cfg_s'(2'h0);
    logic ext_osc = 1'b0;
    logic ext_en = 1'b0;
    logic [1:0] ext_cnt = 2'h0;
    logic clear = 1'b1;
    logic [7:0] row_sink;
    logic [19:0] col_drive;
    logic [6:0] pct_out;
    logic [2:0] row_idx;
    logic frame_done;
    logic sleeping;
    logic [15:0] on_cnt [8];
    logic over_lit;
    int err_count = 0;
    int compares = 0;

    always #2 clk_sys_in = ~clk_sys_in;

    // external oscillator of four clocks; scaled down, but far above the flicker floor
    always @(negedge clk_sys_in) begin
        if (ext_en) begin
            ext_cnt <= ext_cnt + 2'h1;
            if (ext_cnt[0]) ext_osc <= ~ext_osc;
        end
    end

    lmrr_row_refresh #(.INT_OSC_DIV(5)) u_lmrr_row_refresh (
        .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .dot_latch_in(dots), .ctrl0_in(ctrl0),
        .osc_cfg_in(osc_cfg), .ext_osc_in(ext_osc), .row_sink_out(row_sink), .col_drive_out(col_drive),
        .col_current_pct_out(pct_out), .row_index_out(row_idx), .frame_done_out(frame_done),
        .sleeping_out(sleeping)
    );
    lmrr_led_array_model u_lmrr_led_array_model (
        .clk_sys_in(clk_sys_in), .clear_in(clear), .row_sink_in(row_sink), .col_drive_in(col_drive),
        .row_on_cnt_out(on_cnt), .over_lit_out(over_lit)
    );

    task automatic stop_test();
        if (err_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // one whole frame between two completion pulses; per is clocks per display tick
    task automatic measure(input int per, input int on, input logic [6:0] pct);
        int n;
        int bad;
        logic [19:0] expc;
        n = 0;
        bad = 0;
        while (frame_done !== 1'b1 && n < 40000) begin
            @(negedge clk_sys_in);
            n++;
        end
        clear = 1'b1;
        n = 0;
        do begin
            @(negedge clk_sys_in);
            clear = 1'b0;
            n++;
            for (int c = 0; c < 20; c++) expc[c] = dots[c * 8 + row_idx];
            if (row_sink !== 8'h00 && (row_sink !== (8'h01 << row_idx) || col_drive !== expc || pct_out !== pct)) bad++;
        end while (frame_done !== 1'b1 && n < 40000);
        // the model samples a cycle late, so the last lit cycle of row 7 lands one edge on
        @(negedge clk_sys_in);
        check("frame_len", n, 512 * per);
        for (int r = 0; r < 8; r++) begin
            check("row_on", on_cnt[r], (r == 0) ? 0 : on * per);
        end
        check("bad_cycles", bad, 0);
        check("over_lit", over_lit, 1'b0);
    endtask

    initial begin
        repeat (80000) @(posedge clk_sys_in);
        err_count++;
        stop_test();
    end

    initial begin
        repeat (16) @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        repeat (20) @(negedge clk_sys_in);
        check("sleep_flag", sleeping, 1'b1);
        check("sleep_rows", row_sink, 8'h00);
        ctrl0 = lmrr_ctrl0_s'(7'h4F);
        measure(5, 60, 7'h49);
        ctrl0 = lmrr_ctrl0_s'(7'h6D);
        measure(5, 36, 7'h64);
        // a prescale request on the internal source must leave its rate alone
        osc_cfg = lmrr_osc_cfg_s'(2'h1);
        measure(5, 36, 7'h64);
        ctrl0 = lmrr_ctrl0_s'(7'h0D);
        repeat (4) @(negedge clk_sys_in);
        check("sleep_flag", sleeping, 1'b1);
        check("sleep_cols", {row_sink, col_drive}, 28'h0000000);
        // clear for one edge only, so the model keeps counting through the sleep span
        clear = 1'b1;
        @(negedge clk_sys_in);
        clear = 1'b0;
        repeat (2600) begin
            @(negedge clk_sys_in);
            check("sleep_frame", frame_done, 1'b0);
        end
        check("sleep_on", on_cnt[3], 16'h0000);
        ctrl0 = lmrr_ctrl0_s'(7'h5F);
        osc_cfg = lmrr_osc_cfg_s'(2'h2);
        ext_en = 1'b1;
        measure(4, 60, 7'h32);
        ctrl0 = lmrr_ctrl0_s'(7'h7F);
        osc_cfg = lmrr_osc_cfg_s'(2'h3);
        measure(32, 60, 7'h5D);
        stop_test();
    end
endmodule
`default_nettype wire
